// file: logic/channel_regs.sv
// Purpose: One channel's input register and output register pair.
// Assumes: Load and update strobes are one-cycle pulses from the decoder.
// Notes: On a load together with an update the new value goes straight through.
`timescale 1ns/1ps
module channel_regs #(
    parameter int WIDTH = update_decoder_pkg::SAMPLE_WIDTH
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic load_in,
    input wire logic update_in,
    input wire logic [WIDTH-1:0] data_in,
    output logic [WIDTH-1:0] input_reg_out,
    output logic [WIDTH-1:0] output_reg_out
);
    import update_decoder_pkg::*;

    logic [WIDTH-1:0] input_ff;
    logic [WIDTH-1:0] nxt_input;
    logic [WIDTH-1:0] output_ff;
    logic [WIDTH-1:0] nxt_output;

    // Next values of the two registers.
    always_comb begin
        nxt_input = load_in ? data_in : input_ff;
        nxt_output = output_ff;
        if (update_in) begin
            nxt_output = nxt_input;
        end
    end

    // Register both values.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            input_ff <= WIDTH'(SAMPLE_RESET);
            output_ff <= WIDTH'(SAMPLE_RESET);
        end else begin
            input_ff <= nxt_input;
            output_ff <= nxt_output;
        end
    end

    assign input_reg_out = input_ff;
    assign output_reg_out = output_ff;
endmodule : channel_regs

// file: logic/dac_update_command_decoder.sv
// Purpose: Decodes three-byte write frames into input-register loads and output-register updates.
// Assumes: byte_valid_in pulses once per received byte; frame_start_in marks a new frame; frame_stop_in ends it.
//          All three frame inputs are synchronous to clk_in and last one cycle.
// Notes: Commands other than the three handled here are passed over and left to other blocks.
//        Register outputs change at the clock edge that takes the third byte of a frame.
//        frame_done_out pulses for one cycle right after that edge, for every whole frame.
//        frame_invalid_out pulses together with it when the channel code is refused.
//        A stop or a new start before the third byte throws the partial frame away.
//        Bytes outside a frame, and bytes after the third, are ignored.
//        A broadcast code on the plain input write loads every input register.
`timescale 1ns/1ps
module dac_update_command_decoder #(
    parameter int NUM_CH = update_decoder_pkg::NUM_CHANNELS,
    parameter int WIDTH = update_decoder_pkg::SAMPLE_WIDTH
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic frame_start_in,
    input wire logic frame_stop_in,
    input wire logic byte_valid_in,
    input wire logic [7:0] byte_data_in,
    output logic [NUM_CH*WIDTH-1:0] input_regs_out,
    output logic [NUM_CH*WIDTH-1:0] output_regs_out,
    output logic frame_done_out,
    output logic frame_invalid_out
);
    import update_decoder_pkg::*;

    // Frame receiver states: waiting for a start, collecting bytes, and
    // waiting out the rest of a frame whose three bytes are already in.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RECV = 3'b010,
        ST_SKIP = 3'b100
    } frame_state_t;

    // Frame receiver state and byte count.
    frame_state_t state_ff;
    frame_state_t nxt_state;
    logic [1:0] count_ff;
    logic [1:0] nxt_count;

    // Captured command and access byte, and the high data bits.
    logic [7:0] cmd_ff;
    logic [7:0] nxt_cmd;
    logic [7:0] msb_ff;
    logic [7:0] nxt_msb;

    // Status pulses.
    logic done_ff;
    logic nxt_done;
    logic invalid_ff;
    logic nxt_invalid;

    // Decode results and per-channel strobes.
    logic [NUM_CH-1:0] load_vec;
    logic [NUM_CH-1:0] update_vec;
    logic [WIDTH-1:0] sample;
    logic frame_complete;
    logic [3:0] cmd_nib;
    logic [3:0] addr_nib;
    logic [NUM_CH-1:0] sel_one;
    logic [NUM_CH-1:0] target_vec;
    logic broadcast;
    logic addr_ok;

    ////////////////////////////////////////////////////////////////////////
    // Frame assembly.

    // Byte counter and capture; a stop before the third byte discards the frame.
    // Count 0 takes the command and access byte, count 1 the high data bits,
    // and count 2 the low data bits, which are used in the same cycle and not stored.
    // A start always wins, so a master may begin a new frame at any time.
    always_comb begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        nxt_cmd = cmd_ff;
        nxt_msb = msb_ff;
        frame_complete = 1'b0;
        if (frame_start_in) begin
            nxt_state = ST_RECV;
            nxt_count = BYTE_COUNT_RESET;
        end else if (frame_stop_in) begin
            nxt_state = ST_IDLE; // RQ9
            nxt_count = BYTE_COUNT_RESET;
        end else if (byte_valid_in) begin
            unique case (state_ff)
                ST_RECV: begin
                    if (count_ff == BYTE_COUNT_RESET) begin
                        nxt_cmd = byte_data_in;
                        nxt_count = count_ff + 2'h1;
                    end else if (count_ff != BYTE_COUNT_LAST) begin
                        nxt_msb = byte_data_in;
                        nxt_count = count_ff + 2'h1;
                    end else begin
                        frame_complete = 1'b1; // RQ9
                        nxt_state = ST_SKIP;
                    end
                end
                ST_IDLE: begin
                    // No frame is open, so the byte is dropped.
                    nxt_state = ST_IDLE;
                end
                ST_SKIP: begin
                    // The frame is already whole; extra bytes are dropped.
                    nxt_state = ST_SKIP;
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode, valid only in the cycle the third byte arrives.

    // Sample assembled from the first data byte and the upper nibble of the second.
    // The low nibble of the last byte carries no data and is dropped.
    assign sample = {msb_ff, byte_data_in[7:4]}; // RQ6
    assign cmd_nib = cmd_ff[7:4];
    assign addr_nib = cmd_ff[3:0];
    assign broadcast = (addr_nib == ADDR_BROADCAST);
    assign addr_ok = !addr_nib[3] || broadcast; // RQ5

    // One-hot channel select from the low three address bits.
    always_comb begin
        sel_one = '0;
        sel_one[addr_nib[2:0]] = 1'b1; // RQ7
    end

    // Channels that a command reaches: one channel, or all of them on the broadcast code.
    always_comb begin
        target_vec = sel_one;
        if (broadcast) begin
            target_vec = '1; // RQ2 RQ4
        end
    end

    // Strobes for every channel, raised only in the cycle the third byte is taken.
    always_comb begin
        load_vec = '0;
        update_vec = '0;
        nxt_done = 1'b0;
        nxt_invalid = 1'b0;
        if (frame_complete) begin
            // Every whole frame reports done; a refused code also reports invalid.
            nxt_done = 1'b1;
            nxt_invalid = !addr_ok; // RQ5
            if (addr_ok) begin
                unique case (cmd_nib)
                    CMD_UPDATE_ONLY: begin
                        // Data bytes play no part; the stored input values move across.
                        update_vec = target_vec; // RQ1 RQ2
                    end
                    CMD_WRITE_UPDATE: begin
                        // The new value reaches the output at the same edge as the input.
                        load_vec = target_vec; // RQ3 RQ4
                        update_vec = target_vec; // RQ3 RQ4
                    end
                    CMD_WRITE_INPUT: begin
                        // Output registers wait for a later update command.
                        load_vec = target_vec; // RQ8
                    end
                    default: begin
                        // Other command codes belong to other blocks and change no register.
                        load_vec = '0;
                        update_vec = '0;
                    end
                endcase
            end
        end
    end

    // Register the frame receiver state and the captured bytes.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff <= ST_IDLE;
            count_ff <= BYTE_COUNT_RESET;
            cmd_ff <= 8'h00;
            msb_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
            cmd_ff <= nxt_cmd;
            msb_ff <= nxt_msb;
        end
    end

    // Register the status pulses; they clear themselves one cycle later.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            done_ff <= 1'b0;
            invalid_ff <= 1'b0;
        end else begin
            done_ff <= nxt_done;
            invalid_ff <= nxt_invalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel register pairs.
    // Every channel has the same pair of registers; the decoder only steers strobes.
    // All channels share the sample bus, so a broadcast writes the same value everywhere.

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        channel_regs #(
            .WIDTH(WIDTH)
        ) u_regs (
            .clk_in(clk_in),
            .rstn_in(rstn_in),
            .load_in(load_vec[ch]),
            .update_in(update_vec[ch]),
            .data_in(sample),
            .input_reg_out(input_regs_out[ch*WIDTH +: WIDTH]),
            .output_reg_out(output_regs_out[ch*WIDTH +: WIDTH])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Status outputs.

    // Both flags come straight from flip-flops.
    assign frame_done_out = done_ff;
    assign frame_invalid_out = invalid_ff;
endmodule : dac_update_command_decoder

// file: logic/update_decoder_pkg.sv
// Purpose: Constants for the update and write-and-update command decoder.
// Assumes: A serial front end delivers each frame as three whole bytes.
// Notes: Command nibble sits in the top four bits of the first byte.
// Contract
// [RQ1] An update-only command to channels 0 to 7 copies that input register to its output register, data ignored.
// [RQ2] An update-only command with an all-ones channel code copies every input register to its output register.
// [RQ3] A write-and-update command to channels 0 to 7 loads the 12-bit value and updates only that channel's output.
// [RQ4] A write-and-update command with an all-ones code loads and updates all eight channels.
// [RQ5] A channel code with its top bit set, other than all ones, changes no register.
// [RQ6] The master sends sample bits 11 to 4 in the first data byte and bits 3 to 0 in the upper nibble of the second.
// [RQ7] The low three address bits pick channel A to H in binary order; the top bit is zero for one channel.
// [RQ8] The all-zero command writes only the selected input register and leaves its output register alone.
// [RQ9] Nothing is done until all three bytes have arrived; a frame cut short changes nothing.
package update_decoder_pkg;
    localparam int NUM_CHANNELS = 8;
    localparam int SAMPLE_WIDTH = 12;
    localparam logic [3:0] CMD_WRITE_INPUT = 4'h0;
    localparam logic [3:0] CMD_UPDATE_ONLY = 4'h1;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] ADDR_BROADCAST = 4'hF;
    localparam logic [SAMPLE_WIDTH-1:0] SAMPLE_RESET = 12'h000;
    localparam logic [1:0] BYTE_COUNT_RESET = 2'h0;
    localparam logic [1:0] BYTE_COUNT_LAST = 2'h2;
endpackage : update_decoder_pkg

// file: test/dac_update_monitor.sv
// Purpose: Checks register updates of the command decoder.
// Assumes: Sees only the decoder ports.
// Notes: Helper logic follows the byte count and keeps the first two bytes.
`timescale 1ns/1ps
module dac_update_monitor #(
    parameter int NUM_CH = 8,
    parameter int WIDTH = 12
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic frame_start_in,
    input wire logic frame_stop_in,
    input wire logic byte_valid_in,
    input wire logic [7:0] byte_data_in,
    input wire logic [NUM_CH*WIDTH-1:0] input_regs_out,
    input wire logic [NUM_CH*WIDTH-1:0] output_regs_out,
    input wire logic frame_done_out,
    input wire logic frame_invalid_out
);
    logic [1:0] cnt_ff, nxt_cnt;
    logic [7:0] b0_ff, b1_ff, nxt_b0, nxt_b1;
    logic take, fire, bad;
    logic [11:0] val;
    // Count 3 means idle; a byte is taken only inside a frame.
    always_comb begin
        take = byte_valid_in && !frame_start_in && !frame_stop_in && cnt_ff != 2'h3;
        fire = take && cnt_ff == 2'h2;
        bad = b0_ff[3] && b0_ff[3:0] != 4'hF;
        val = {b1_ff, byte_data_in[7:4]};
        nxt_cnt = frame_start_in ? 2'h0 : (frame_stop_in ? 2'h3 : cnt_ff + {1'b0, take});
        nxt_b0 = (take && cnt_ff == 2'h0) ? byte_data_in : b0_ff;
        nxt_b1 = (take && cnt_ff == 2'h1) ? byte_data_in : b1_ff;
    end
    // Registers the helper state.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_ff <= 2'h3;
            b0_ff <= 8'h00;
            b1_ff <= 8'h00;
        end else begin
            cnt_ff <= nxt_cnt;
            b0_ff <= nxt_b0;
            b1_ff <= nxt_b1;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_last_byte;
        fire;
    endsequence
    chk_done_after_last: assert property (s_last_byte |=> frame_done_out)
        else $error("done missing after third byte");
    chk_done_only_frame: assert property (!fire |=> !frame_done_out)
        else $error("done without a whole frame");
    chk_invalid_only_bad: assert property (!(fire && bad) |=> !frame_invalid_out)
        else $error("invalid raised for a good code");
    chk_quiet_mid_frame: assert property (!fire |=> $stable(input_regs_out) && $stable(output_regs_out))
        else $error("registers changed without a full frame");
    chk_invalid_code: assert property (fire && bad |=> frame_invalid_out && $stable(input_regs_out)
        && $stable(output_regs_out))
        else $error("invalid channel code acted on");
    chk_update_one: assert property (fire && b0_ff[7:3] == 5'h02 |=> output_regs_out[b0_ff[2:0]*WIDTH +: WIDTH]
        == $past(input_regs_out[b0_ff[2:0]*WIDTH +: WIDTH]))
        else $error("single update wrong");
    chk_update_all: assert property (fire && b0_ff == 8'h1F |=> output_regs_out == $past(input_regs_out))
        else $error("broadcast update wrong");
    chk_write_upd_one: assert property (fire && b0_ff[7:3] == 5'h06 |=> input_regs_out[b0_ff[2:0]*WIDTH +: WIDTH]
        == $past(val) && output_regs_out[b0_ff[2:0]*WIDTH +: WIDTH] == $past(val))
        else $error("write and update wrong");
    chk_write_upd_all: assert property (fire && b0_ff == 8'h3F |=> input_regs_out == {NUM_CH{$past(val)}}
        && output_regs_out == {NUM_CH{$past(val)}})
        else $error("broadcast write and update wrong");
    chk_write_only: assert property (fire && b0_ff[7:3] == 5'h00 |=> $stable(output_regs_out)
        && input_regs_out[b0_ff[2:0]*WIDTH +: WIDTH] == $past(val))
        else $error("input write touched output");
endmodule : dac_update_monitor
bind dac_update_command_decoder dac_update_monitor #(.NUM_CH(NUM_CH), .WIDTH(WIDTH)) mon (.clk_in(clk_in),
    .rstn_in(rstn_in), .frame_start_in(frame_start_in), .frame_stop_in(frame_stop_in),
    .byte_valid_in(byte_valid_in), .byte_data_in(byte_data_in), .input_regs_out(input_regs_out),
    .output_regs_out(output_regs_out), .frame_done_out(frame_done_out), .frame_invalid_out(frame_invalid_out));

// file: test/frame_source.sv
// Purpose: Serial front end model that hands frames to the decoder byte by byte.
// Assumes: Drives only on falling clock edges.
// Notes: The data line shows the inverse of the last byte while no byte is valid.
`timescale 1ns/1ps
module frame_source (
    input wire logic clk_in,
    output logic start_out,
    output logic stop_out,
    output logic valid_out,
    output logic [7:0] data_out
);
    // Idle levels at time zero.
    initial begin
        start_out = 1'b0;
        stop_out = 1'b0;
        valid_out = 1'b0;
        data_out = 8'h00;
    end

    // Sends the first n bytes of a frame, sample high bits first, then stops.
    task automatic send(input logic [23:0] f, input int n);
        @(negedge clk_in) start_out = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_in) start_out = 1'b0;
            valid_out = 1'b1;
            data_out = f[23-8*i -: 8];
        end
        @(negedge clk_in) valid_out = 1'b0;
        data_out = ~data_out;
        stop_out = 1'b1;
        @(negedge clk_in) stop_out = 1'b0;
    endtask : send
endmodule : frame_source

// file: test/tb_top.sv
// Purpose: Self-checking bench for the command decoder.
// Assumes: One clock; frames come from the source model.
// Notes: A queue-free integer model predicts every register.
`timescale 1ns/1ps
module tb_top;
    import update_decoder_pkg::*;
    logic clk_in = 1'b0, rstn_in = 1'b0, fs, fp, bv, done, inv;
    logic [7:0] bd;
    logic [95:0] in_q, out_q, ei, eo;
    logic [31:0] seed = 32'h0000004A;
    logic [3:0] cmds[3] = '{CMD_WRITE_INPUT, CMD_UPDATE_ONLY, CMD_WRITE_UPDATE};
    int err_total = 0, checks_done = 0, cycles = 0, n_done = 0, n_inv = 0, e_done = 0, e_inv = 0;
    int in_m[8], out_m[8];
    dac_update_command_decoder dut (.clk_in(clk_in), .rstn_in(rstn_in), .frame_start_in(fs), .frame_stop_in(fp),
        .byte_valid_in(bv), .byte_data_in(bd), .input_regs_out(in_q), .output_regs_out(out_q),
        .frame_done_out(done), .frame_invalid_out(inv));
    frame_source src (.clk_in(clk_in), .start_out(fs), .stop_out(fp), .valid_out(bv), .data_out(bd));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [95:0] s, input logic [95:0] e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic results();
        if (err_total == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    // Sends a frame, updates the model when it is whole, then compares.
    task automatic frame(input logic [7:0] b0, input int n);
        logic [31:0] r;
        r = rnd();
        src.send({b0, r[15:0]}, n);
        if (n == 3 && b0[3] && b0[3:0] != 4'hF) e_inv++;
        for (int ch = 0; ch < 8 && n == 3 && !(b0[3] && b0[3:0] != 4'hF); ch++) begin
            if (b0[3:0] == 4'hF || ch == b0[3:0]) begin
                if (b0[7:4] == 4'h0 || b0[7:4] == 4'h3) in_m[ch] = r[15:4];
                if (b0[7:4] == 4'h1 || b0[7:4] == 4'h3) out_m[ch] = in_m[ch];
            end
        end
        e_done += (n == 3);
        for (int ch = 0; ch < 8; ch++) begin
            ei[ch*12 +: 12] = in_m[ch][11:0];
            eo[ch*12 +: 12] = out_m[ch][11:0];
        end
        chk(in_q, ei);
        chk(out_q, eo);
    endtask : frame
    initial forever #12.5 clk_in = ~clk_in;
    // Tallies pulses mid-cycle, where they have settled, and cuts a hang short.
    always @(negedge clk_in) begin
        cycles++;
        n_done += (done === 1'b1);
        n_inv += (inv === 1'b1);
        if (cycles == 20000) begin
            err_total++;
            results();
        end
    end
    // Every handled command with every channel code, then cut frames, then random frames, then unhandled command codes.
    initial begin
        logic [31:0] r;
        for (int ch = 0; ch < 8; ch++) begin
            in_m[ch] = 0;
            out_m[ch] = 0;
        end
        repeat (6) @(posedge clk_in);
        @(negedge clk_in) rstn_in = 1'b1;
        for (int c = 0; c < 3; c++) for (int a = 0; a < 16; a++) frame({cmds[c], a[3:0]}, 3);
        repeat (12) begin
            r = rnd();
            frame({cmds[r[9:8] % 3], r[3:0]}, 1 + r[4]);
        end
        repeat (30) begin
            r = rnd();
            frame({cmds[r[9:8] % 3], r[3:0]}, 3);
        end
        repeat (8) begin
            r = rnd();
            frame({r[7:4] | 4'h4, r[3:0]}, 3);
        end
        chk(96'(n_done), 96'(e_done));
        chk(96'(n_inv), 96'(e_inv));
        results();
    end
endmodule : tb_top
